// >>> hw/nfs_pkg.sv
// Shared constants and types for the flash command sequencer.
package nfs_pkg;
  localparam int NDIE = 2;
  localparam int NPLANE = 4;
  localparam int DIE_W = 1;
  localparam int PLANE_W = 2;
  localparam int COL_W = 4;
  localparam int HI_W = DIE_W + PLANE_W;
  localparam int CIDX_W = HI_W + COL_W;
  localparam int CACHE_N = NDIE * NPLANE * (2 ** COL_W);
  localparam int PAGE_W = 10;
  localparam int PLANE_LSB = 10;
  localparam int DIE_ROW_BIT = 22;
  localparam logic [7:0] CMD_READ_MODE = 8'h00;
  localparam logic [7:0] CMD_READ_GO = 8'h30;
  localparam logic [7:0] CMD_READ_MP = 8'h32;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_DIE = 8'h78;
  localparam logic [7:0] CMD_COLCHG = 8'h05;
  localparam logic [7:0] CMD_COLCHG_DIE = 8'h06;
  localparam logic [7:0] CMD_COL_GO = 8'hE0;
  localparam logic [7:0] CMD_PROG = 8'h80;
  localparam logic [7:0] CMD_WCOL = 8'h85;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
  localparam logic [7:0] CMD_ERASE = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [2:0] ADDR_FULL = 3'h5;
  localparam logic [2:0] ADDR_ROW = 3'h3;
  localparam logic [2:0] ADDR_COL = 3'h2;
  localparam logic [2:0] ADDR_FEAT = 3'h1;
  localparam logic [2:0] FEAT_LAST = 3'h3;
  localparam logic [7:0] FEAT_OTP = 8'h90;
  localparam logic [7:0] FEAT_PCLR = 8'h01;
  localparam int ST_WPN = 7;
  localparam int ST_RDY = 6;
  localparam int ST_ARRAY_READY_BIT = 5;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] OTP_MARK = 8'hA5;
  localparam int CLK_MHZ = 125;
  localparam int T_READ_NS = 2000;
  localparam int T_PROG_NS = 4000;
  localparam int T_ERASE_NS = 8000;
  localparam int T_CACHE_NS = 400;
  localparam logic [15:0] RD_CYC = 16'((T_READ_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] PROG_CYC = 16'((T_PROG_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] ERASE_CYC = 16'((T_ERASE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] CACHE_CYC = 16'((T_CACHE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_RDTIME = 12'h008;
  localparam int CTRL_PCLR = 0;
  localparam int CTRL_OTP = 1;
  localparam int STAT_RDY_LSB = 0;
  localparam int STAT_ARRAY_READY_LSB = 4;
  localparam int STAT_SEL_BIT = 8;
  localparam int STAT_MODE_BIT = 9;
  localparam int STAT_RB_BIT = 12;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DIN = 2'b10,
    ST_FEAT = 2'b11
  } nfs_state_type;
endpackage : nfs_pkg

// >>> hw/nfs_die_if.sv
// Handshake between the sequencer and one die's busy timer.
`timescale 1ns/10ps
interface nfs_die_if;
  logic start_full;
  logic start_cache;
  logic [15:0] len;
  logic rdy;
  logic idle;
  modport ctl (output start_full, output start_cache, output len, input rdy, input idle);
  modport die (input start_full, input start_cache, input len, output rdy, output idle);
endinterface : nfs_die_if

// >>> hw/nfs_die_timer.sv
// Busy timer of one die: cache-ready and array-ready counters.
`timescale 1ns/10ps
module nfs_die_timer (
  input wire logic sys_clk,
  input wire logic rst,
  nfs_die_if.die dif
);
  logic [15:0] rdy_cnt_q;
  logic [15:0] arr_cnt_q;

  // A cache operation frees the cache register early while the array keeps working.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdy_cnt_q <= 16'h0000;
      arr_cnt_q <= 16'h0000;
    end else if (dif.start_full) begin
      rdy_cnt_q <= dif.len;
      arr_cnt_q <= dif.len;
    end else if (dif.start_cache) begin
      rdy_cnt_q <= nfs_pkg::CACHE_CYC;
      arr_cnt_q <= dif.len;
    end else begin
      if (rdy_cnt_q != 16'h0000) begin
        rdy_cnt_q <= rdy_cnt_q - 16'h0001;
      end
      if (arr_cnt_q != 16'h0000) begin
        arr_cnt_q <= arr_cnt_q - 16'h0001;
      end
    end
  end

  assign dif.rdy = (rdy_cnt_q == 16'h0000);
  assign dif.idle = (arr_cnt_q == 16'h0000) && (rdy_cnt_q == 16'h0000);
endmodule : nfs_die_timer

// >>> hw/nfs_seq.sv
// Flash command sequencer: OTP read, multi-plane addressing, per-die status.
`timescale 1ns/10ps
// Notes on behaviour
// - Read confirm drops ready and array-ready of the addressed die for the read time.
// - Data output starts at the column given in the address cycles.
// - Column change 05h then E0h repositions output during an OTP read.
// - Each plane has its own cache; plane chosen by low block address bits.
// - Shared ready/busy stays low while any die is busy.
// - Status bit 6 means cache ready; bit 5 means everything on the die finished.
// - A 70h after 78h reports the die that 78h selected.
// - 80h clears every cache register unless configured otherwise.
// - With program-clear set, 80h keeps caches of non-addressed planes.
// - Only the selected die drives the data bus on output cycles.
module nfs_seq (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cyc_valid,
  input wire logic cyc_cle,
  input wire logic cyc_ale,
  input wire logic [7:0] cyc_data,
  input wire logic rd_strobe,
  output logic [7:0] dq_out,
  output logic [1:0] dq_oe,
  output logic rb_n,
  output logic otp_mode
);
  function automatic logic [nfs_pkg::HI_W-1:0] f_hi(input logic [23:0] row);
    f_hi = {row[nfs_pkg::DIE_ROW_BIT], row[nfs_pkg::PLANE_LSB +: nfs_pkg::PLANE_W]};
  endfunction : f_hi

  function automatic logic [2:0] f_need(input logic [7:0] cmd);
    if (cmd == nfs_pkg::CMD_READ_MODE || cmd == nfs_pkg::CMD_COLCHG_DIE ||
        cmd == nfs_pkg::CMD_PROG) begin
      f_need = nfs_pkg::ADDR_FULL;
    end else if (cmd == nfs_pkg::CMD_STATUS_DIE || cmd == nfs_pkg::CMD_ERASE) begin
      f_need = nfs_pkg::ADDR_ROW;
    end else if (cmd == nfs_pkg::CMD_COLCHG || cmd == nfs_pkg::CMD_WCOL) begin
      f_need = nfs_pkg::ADDR_COL;
    end else begin
      f_need = nfs_pkg::ADDR_FEAT;
    end
  endfunction : f_need

  // Stand-in for array contents; OTP pages carry a distinct mark.
  function automatic logic [7:0] f_pattern(input logic [9:0] page, input logic [3:0] col,
                                           input logic otp);
    f_pattern = page[7:0] ^ {4'h0, col} ^ (otp ? nfs_pkg::OTP_MARK : 8'h00);
  endfunction : f_pattern

  nfs_pkg::nfs_state_type state_q;
  logic [7:0] cmd_q;
  logic [2:0] addr_cnt_q;
  logic [39:0] addr_q;
  logic [7:0] feat_addr_q;
  logic [7:0] feat_p1_q;
  logic [2:0] feat_cnt_q;
  logic [nfs_pkg::DIE_W-1:0] sel_die_q;
  logic [nfs_pkg::PLANE_W-1:0] sel_plane_q;
  logic [nfs_pkg::COL_W-1:0] col_q;
  logic status_mode_q;
  logic out_active_q;
  logic otp_q;
  logic pclr_q;
  logic [15:0] rdtime_q;
  logic [7:0] cache_q [nfs_pkg::CACHE_N];
  logic [nfs_pkg::NDIE-1:0] die_rdy, die_idle;
  logic is_cmd, is_addr, is_din;
  logic [23:0] row5, row_now;
  logic [nfs_pkg::HI_W-1:0] hi5, hi_now;
  logic [nfs_pkg::COL_W-1:0] col5;
  logic ev_read, ev_fill, ev_st70, ev_st78, ev_col05, ev_col06;
  logic ev_prog_cmd, ev_prog_addr, ev_prog10, ev_prog15, ev_erase, ev_addr_last;

  assign is_cmd = cyc_valid && cyc_cle;
  assign is_addr = cyc_valid && cyc_ale && !cyc_cle;
  assign is_din = cyc_valid && !cyc_cle && !cyc_ale && state_q == nfs_pkg::ST_DIN;
  assign row5 = addr_q[39:16];
  assign hi5 = f_hi(row5);
  assign col5 = addr_q[nfs_pkg::COL_W-1:0];
  // The last address byte completes the row in the cycle it arrives.
  assign row_now = (cmd_q == nfs_pkg::CMD_PROG) ? {cyc_data, addr_q[31:16]}
                                                : {cyc_data, addr_q[15:0]};
  assign hi_now = f_hi(row_now);
  assign ev_addr_last = is_addr && state_q == nfs_pkg::ST_ADDR &&
                        addr_cnt_q == f_need(cmd_q) - 3'h1;

  always_comb begin
    ev_fill = is_cmd && cmd_q == nfs_pkg::CMD_READ_MODE && addr_cnt_q == nfs_pkg::ADDR_FULL &&
              (cyc_data == nfs_pkg::CMD_READ_GO || cyc_data == nfs_pkg::CMD_READ_MP);
    ev_read = ev_fill && cyc_data == nfs_pkg::CMD_READ_GO;
    ev_st70 = is_cmd && cyc_data == nfs_pkg::CMD_STATUS;
    ev_st78 = ev_addr_last && cmd_q == nfs_pkg::CMD_STATUS_DIE;
    ev_col05 = is_cmd && cyc_data == nfs_pkg::CMD_COL_GO && cmd_q == nfs_pkg::CMD_COLCHG &&
               addr_cnt_q == nfs_pkg::ADDR_COL;
    ev_col06 = is_cmd && cyc_data == nfs_pkg::CMD_COL_GO && cmd_q == nfs_pkg::CMD_COLCHG_DIE &&
               addr_cnt_q == nfs_pkg::ADDR_FULL;
    ev_prog_cmd = is_cmd && cyc_data == nfs_pkg::CMD_PROG;
    ev_prog_addr = ev_addr_last && cmd_q == nfs_pkg::CMD_PROG;
    ev_prog10 = is_cmd && cyc_data == nfs_pkg::CMD_PROG_GO && state_q == nfs_pkg::ST_DIN;
    ev_prog15 = is_cmd && cyc_data == nfs_pkg::CMD_PROG_CACHE && state_q == nfs_pkg::ST_DIN;
    ev_erase = is_cmd && cyc_data == nfs_pkg::CMD_ERASE_GO && cmd_q == nfs_pkg::CMD_ERASE &&
               addr_cnt_q == nfs_pkg::ADDR_ROW;
  end

  nfs_die_if dif [nfs_pkg::NDIE] ();

  for (genvar g = 0; g < nfs_pkg::NDIE; g++) begin : g_die
    assign dif[g].start_full = (ev_read && hi5[nfs_pkg::HI_W-1] == g) ||
                               (ev_prog10 && sel_die_q == g) ||
                               (ev_erase && addr_q[nfs_pkg::DIE_ROW_BIT] == g);
    assign dif[g].start_cache = ev_prog15 && sel_die_q == g;
    assign dif[g].len = ev_read ? rdtime_q : (ev_erase ? nfs_pkg::ERASE_CYC : nfs_pkg::PROG_CYC);
    assign die_rdy[g] = dif[g].rdy;
    assign die_idle[g] = dif[g].idle;
    nfs_die_timer u_timer (
      .sys_clk(sys_clk),
      .rst(rst),
      .dif(dif[g])
    );
  end

  assign rb_n = &(die_rdy & die_idle);

  // Command, address and feature cycle sequencing.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= nfs_pkg::ST_IDLE;
      cmd_q <= 8'hFF;
      addr_cnt_q <= 3'h0;
      addr_q <= 40'h0000000000;
      feat_addr_q <= 8'h00;
      feat_p1_q <= 8'h00;
      feat_cnt_q <= 3'h0;
    end else if (is_cmd) begin
      cmd_q <= cyc_data;
      addr_cnt_q <= 3'h0;
      case (cyc_data)
        nfs_pkg::CMD_READ_MODE, nfs_pkg::CMD_COLCHG, nfs_pkg::CMD_COLCHG_DIE, nfs_pkg::CMD_PROG,
        nfs_pkg::CMD_WCOL, nfs_pkg::CMD_ERASE, nfs_pkg::CMD_STATUS_DIE,
        nfs_pkg::CMD_SET_FEAT: begin
          state_q <= nfs_pkg::ST_ADDR;
        end
        default: begin
          state_q <= nfs_pkg::ST_IDLE;
        end
      endcase
    end else if (is_addr && state_q == nfs_pkg::ST_ADDR) begin
      addr_q[{addr_cnt_q, 3'h0} +: 8] <= cyc_data;
      addr_cnt_q <= addr_cnt_q + 3'h1;
      if (ev_addr_last) begin
        if (cmd_q == nfs_pkg::CMD_PROG || cmd_q == nfs_pkg::CMD_WCOL) begin
          state_q <= nfs_pkg::ST_DIN;
        end else if (cmd_q == nfs_pkg::CMD_SET_FEAT) begin
          state_q <= nfs_pkg::ST_FEAT;
          feat_addr_q <= cyc_data;
          feat_cnt_q <= 3'h0;
        end else begin
          state_q <= nfs_pkg::ST_IDLE;
        end
      end
    end else if (cyc_valid && !cyc_cle && !cyc_ale && state_q == nfs_pkg::ST_FEAT) begin
      feat_cnt_q <= feat_cnt_q + 3'h1;
      if (feat_cnt_q == 3'h0) begin
        feat_p1_q <= cyc_data;
      end
      if (feat_cnt_q == nfs_pkg::FEAT_LAST) begin
        state_q <= nfs_pkg::ST_IDLE;
      end
    end
  end

  // Die, plane and column selection, and the output mode of the bus.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sel_die_q <= '0;
      sel_plane_q <= '0;
      col_q <= '0;
      status_mode_q <= 1'b0;
      out_active_q <= 1'b0;
    end else begin
      if (ev_fill) begin
        sel_die_q <= hi5[nfs_pkg::HI_W-1];
        sel_plane_q <= hi5[nfs_pkg::PLANE_W-1:0];
        col_q <= col5;
        status_mode_q <= 1'b0;
        out_active_q <= 1'b1;
      end else if (ev_st70) begin
        status_mode_q <= 1'b1;
        out_active_q <= 1'b1;
      end else if (ev_st78) begin
        sel_die_q <= hi_now[nfs_pkg::HI_W-1];
        sel_plane_q <= hi_now[nfs_pkg::PLANE_W-1:0];
        status_mode_q <= 1'b1;
        out_active_q <= 1'b1;
      end else if (ev_col05) begin
        col_q <= col5;
        status_mode_q <= 1'b0;
        out_active_q <= 1'b1;
      end else if (ev_col06) begin
        sel_die_q <= hi5[nfs_pkg::HI_W-1];
        sel_plane_q <= hi5[nfs_pkg::PLANE_W-1:0];
        col_q <= col5;
        status_mode_q <= 1'b0;
        out_active_q <= 1'b1;
      end else if (is_cmd && cyc_data == nfs_pkg::CMD_READ_MODE) begin
        status_mode_q <= 1'b0;
        out_active_q <= 1'b1;
      end else if (is_cmd && cyc_data != nfs_pkg::CMD_COLCHG &&
                   cyc_data != nfs_pkg::CMD_COLCHG_DIE && cyc_data != nfs_pkg::CMD_COL_GO &&
                   cyc_data != nfs_pkg::CMD_STATUS_DIE) begin
        out_active_q <= 1'b0;
      end else if (ev_prog_addr) begin
        sel_die_q <= hi_now[nfs_pkg::HI_W-1];
        sel_plane_q <= hi_now[nfs_pkg::PLANE_W-1:0];
        col_q <= addr_q[nfs_pkg::COL_W-1:0];
      end else if (ev_addr_last && cmd_q == nfs_pkg::CMD_WCOL) begin
        col_q <= addr_q[nfs_pkg::COL_W-1:0];
      end else if (is_din) begin
        col_q <= col_q + 1'b1;
      end else if (rd_strobe && out_active_q && !status_mode_q) begin
        col_q <= col_q + 1'b1;
      end
    end
  end

  // Configuration: software and the feature command share the OTP and program-clear bits; only software sets the read time.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      otp_q <= 1'b0;
      pclr_q <= 1'b0;
      rdtime_q <= nfs_pkg::RD_CYC;
    end else if (psel && penable && pwrite && paddr == nfs_pkg::REG_CTRL) begin
      pclr_q <= pwdata[nfs_pkg::CTRL_PCLR];
      otp_q <= pwdata[nfs_pkg::CTRL_OTP];
    end else if (psel && penable && pwrite && paddr == nfs_pkg::REG_RDTIME) begin
      rdtime_q <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
    end else if (is_cmd && cyc_data == nfs_pkg::CMD_RESET) begin
      otp_q <= 1'b0;
    end else if (state_q == nfs_pkg::ST_FEAT && cyc_valid && !cyc_cle && !cyc_ale &&
                 feat_cnt_q == nfs_pkg::FEAT_LAST) begin
      if (feat_addr_q == nfs_pkg::FEAT_OTP) begin
        otp_q <= feat_p1_q[0];
      end else if (feat_addr_q == nfs_pkg::FEAT_PCLR) begin
        pclr_q <= feat_p1_q[0];
      end
    end
  end

  assign otp_mode = otp_q;

  // Cache registers, one block of bytes per die and plane.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < nfs_pkg::CACHE_N; i++) begin
        cache_q[i] <= nfs_pkg::ERASED;
      end
    end else begin
      for (int i = 0; i < nfs_pkg::CACHE_N; i++) begin
        if (ev_prog_cmd && !pclr_q) begin
          cache_q[i] <= nfs_pkg::ERASED;
        end else if (ev_prog_addr && pclr_q &&
                     nfs_pkg::HI_W'(i >> nfs_pkg::COL_W) == hi_now) begin
          cache_q[i] <= nfs_pkg::ERASED;
        end else if (ev_fill && nfs_pkg::HI_W'(i >> nfs_pkg::COL_W) == hi5) begin
          cache_q[i] <= f_pattern(row5[nfs_pkg::PAGE_W-1:0], nfs_pkg::COL_W'(i), otp_q);
        end
      end
      if (is_din) begin
        cache_q[{sel_die_q, sel_plane_q, col_q}] <= cyc_data;
      end
    end
  end

  // Output byte: status of the selected die or its cache byte at the column.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dq_out <= 8'h00;
    end else if (status_mode_q) begin
      dq_out <= 8'h00;
      dq_out[nfs_pkg::ST_WPN] <= 1'b1;
      dq_out[nfs_pkg::ST_RDY] <= die_rdy[sel_die_q];
      dq_out[nfs_pkg::ST_ARRAY_READY_BIT] <= die_idle[sel_die_q];
    end else begin
      dq_out <= cache_q[{sel_die_q, sel_plane_q, col_q}];
    end
  end

  for (genvar g = 0; g < nfs_pkg::NDIE; g++) begin : g_oe
    assign dq_oe[g] = out_active_q && rd_strobe && sel_die_q == g;
  end

  // APB slave, no wait states; read data is latched in the setup cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && paddr != nfs_pkg::REG_CTRL &&
                   paddr != nfs_pkg::REG_STATUS && paddr != nfs_pkg::REG_RDTIME;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= 32'h00000000;
      if (paddr == nfs_pkg::REG_CTRL) begin
        prdata[nfs_pkg::CTRL_PCLR] <= pclr_q;
        prdata[nfs_pkg::CTRL_OTP] <= otp_q;
      end else if (paddr == nfs_pkg::REG_STATUS) begin
        prdata[nfs_pkg::STAT_RDY_LSB +: nfs_pkg::NDIE] <= die_rdy;
        prdata[nfs_pkg::STAT_ARRAY_READY_LSB +: nfs_pkg::NDIE] <= die_idle;
        prdata[nfs_pkg::STAT_SEL_BIT] <= sel_die_q;
        prdata[nfs_pkg::STAT_MODE_BIT] <= status_mode_q;
        prdata[nfs_pkg::STAT_RB_BIT] <= rb_n;
      end else if (paddr == nfs_pkg::REG_RDTIME) begin
        prdata[15:0] <= rdtime_q;
      end
    end
  end

  a_read_busy_start: assert property (@(posedge sys_clk) disable iff (rst)
    ev_read |=> !die_rdy[$past(hi5[nfs_pkg::HI_W-1])] && !die_idle[$past(hi5[nfs_pkg::HI_W-1])])
    else $error("read confirm did not drop ready of the addressed die");
  a_rb_any_busy: assert property (@(posedge sys_clk) disable iff (rst)
    (!(&die_idle)) |-> !rb_n)
    else $error("ready/busy high while a die is busy");
  a_cache_prog_busy: assert property (@(posedge sys_clk) disable iff (rst)
    ev_prog15 |=> !die_rdy[$past(sel_die_q)] && !die_idle[$past(sel_die_q)])
    else $error("cache program did not mark the die busy");
  a_status_same_die: assert property (@(posedge sys_clk) disable iff (rst)
    ev_st70 |=> status_mode_q && sel_die_q == $past(sel_die_q))
    else $error("plain status lost the die picked by per-die status");
  a_col_start: assert property (@(posedge sys_clk) disable iff (rst)
    ev_read |=> col_q == $past(col5) && !status_mode_q)
    else $error("data output does not start at the given column");
  a_col_change: assert property (@(posedge sys_clk) disable iff (rst)
    ev_col05 |=> col_q == $past(col5) && out_active_q)
    else $error("column change not applied");
  a_plane_pick: assert property (@(posedge sys_clk) disable iff (rst)
    ev_fill |=> sel_plane_q == $past(row5[nfs_pkg::PLANE_LSB +: nfs_pkg::PLANE_W]))
    else $error("plane not taken from low block bits");
  a_oe_selected: assert property (@(posedge sys_clk) disable iff (rst)
    (dq_oe != 2'h0) |-> $onehot(dq_oe) && dq_oe[sel_die_q])
    else $error("unselected die drives the bus");
  a_clear_all: assert property (@(posedge sys_clk) disable iff (rst)
    ev_prog_cmd && !pclr_q |=> cache_q[0] == nfs_pkg::ERASED &&
                               cache_q[{1'b1, 2'h1, 4'h1}] == nfs_pkg::ERASED)
    else $error("program command did not clear the caches");
  a_keep_other: assert property (@(posedge sys_clk) disable iff (rst)
    ev_prog_cmd && pclr_q |=> cache_q[{1'b1, 2'h1, 4'h1}] == $past(cache_q[{1'b1, 2'h1, 4'h1}]))
    else $error("program command cleared a cache despite program-clear");
endmodule : nfs_seq

// >>> bench/nfs_host.sv
// Host controller model that drives command, address and data-input cycles.
`timescale 1ns/10ps
module nfs_host (
  input wire logic sys_clk,
  output logic cyc_valid,
  output logic cyc_cle,
  output logic cyc_ale,
  output logic [7:0] cyc_data,
  output logic rd_strobe
);
  initial begin
    {cyc_valid, cyc_cle, cyc_ale, cyc_data, rd_strobe} = 12'h000;
  end
  // Between cycles the data lines carry the inverse byte, so a stale byte never looks valid.
  task automatic put(input logic cle, input logic ale, input logic [7:0] d);
    @(posedge sys_clk);
    {cyc_valid, cyc_cle, cyc_ale, cyc_data} <= {1'b1, cle, ale, d};
    @(posedge sys_clk);
    {cyc_valid, cyc_cle, cyc_ale, cyc_data} <= {3'h0, ~d};
  endtask : put
  task automatic cmd(input logic [7:0] d);
    put(1'b1, 1'b0, d);
  endtask : cmd
  task automatic row3(input logic [7:0] r0, input logic [7:0] r1, input logic [7:0] r2);
    put(1'b0, 1'b1, r0);
    put(1'b0, 1'b1, r1);
    put(1'b0, 1'b1, r2);
  endtask : row3
  task automatic addr5(input logic [7:0] c0, input logic [7:0] r0, input logic [7:0] r1,
                       input logic [7:0] r2);
    put(1'b0, 1'b1, c0);
    put(1'b0, 1'b1, 8'h00);
    row3(r0, r1, r2);
  endtask : addr5
  task automatic strobe(input logic on);
    @(posedge sys_clk);
    rd_strobe <= on;
  endtask : strobe
endmodule : nfs_host

// >>> bench/tb.sv
// Self-checking bench for the flash command sequencer.
`timescale 1ns/10ps
module tb;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, rb_n, otp_mode;
  logic cyc_valid, cyc_cle, cyc_ale, rd_strobe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic se;
  logic [7:0] cyc_data, dq_out;
  logic [1:0] dq_oe;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  nfs_seq u_nfs_seq (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cyc_valid(cyc_valid), .cyc_cle(cyc_cle), .cyc_ale(cyc_ale),
    .cyc_data(cyc_data), .rd_strobe(rd_strobe), .dq_out(dq_out), .dq_oe(dq_oe),
    .rb_n(rb_n), .otp_mode(otp_mode));
  nfs_host u_nfs_host (.sys_clk(sys_clk), .cyc_valid(cyc_valid), .cyc_cle(cyc_cle),
    .cyc_ale(cyc_ale), .cyc_data(cyc_data), .rd_strobe(rd_strobe));
  always #4 sys_clk = ~sys_clk;
  task automatic tally_and_finish;
    if (errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 32'h0);
    cmp(nm, e, r & m);
  endtask : rd
  task automatic wait_rb;
    for (int i = 0; i < 1200 && rb_n !== 1'b1; i++) step(1);
    cmp("rb_n", 32'h1, 32'(rb_n));
  endtask : wait_rb
  // Takes one byte on a strobe, then looks at the following column.
  task automatic take(input logic [1:0] oe, input logic [7:0] nxt);
    u_nfs_host.strobe(1'b1);
    #1;
    cmp("dq_oe", 32'(oe), 32'(dq_oe));
    u_nfs_host.strobe(1'b0);
    step(1);
    cmp("dq_out", 32'(nxt), 32'(dq_out));
  endtask : take
  task automatic colchg(input logic [7:0] c, input logic [7:0] e);
    u_nfs_host.cmd(nfs_pkg::CMD_COLCHG);
    u_nfs_host.put(1'b0, 1'b1, c);
    u_nfs_host.put(1'b0, 1'b1, 8'h00);
    u_nfs_host.cmd(nfs_pkg::CMD_COL_GO);
    step(1);
    cmp("dq_out", 32'(e), 32'(dq_out));
  endtask : colchg
  task automatic die1_peek(input logic [7:0] e);
    u_nfs_host.cmd(nfs_pkg::CMD_STATUS_DIE);
    u_nfs_host.row3(8'h02, 8'h04, 8'h40);
    colchg(8'h01, e);
  endtask : die1_peek
  initial begin
    {sys_clk, rst, psel, penable, pwrite, paddr, pwdata} = {2'b01, 3'h0, 12'h000, 32'h0};
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    step(1);
    cmp("rb_n", 32'h1, 32'(rb_n));
    cmp("otp_mode", 32'h0, 32'(otp_mode));
    rd(nfs_pkg::REG_RDTIME, 32'hFFFF, 32'h00FA, "rdtime");
    rd(nfs_pkg::REG_STATUS, 32'h1033, 32'h1033, "status");
    rd(12'h00C, 32'hFFFFFFFF, 32'h0, "unmapped");
    cmp("pslverr", 32'h1, 32'(se));
    apb(1'b1, nfs_pkg::REG_CTRL, 32'h2);
    step(1);
    cmp("otp_mode", 32'h1, 32'(otp_mode));
    u_nfs_host.cmd(nfs_pkg::CMD_READ_MODE);
    u_nfs_host.addr5(8'h03, 8'h05, 8'h00, 8'h00);
    u_nfs_host.cmd(nfs_pkg::CMD_READ_GO);
    step(1);
    cmp("rb_n", 32'h0, 32'(rb_n));
    rd(nfs_pkg::REG_STATUS, 32'h1033, 32'h0022, "status");
    wait_rb();
    u_nfs_host.cmd(nfs_pkg::CMD_STATUS);
    step(1);
    cmp("dq_out", 32'h0E0, 32'(dq_out));
    u_nfs_host.cmd(nfs_pkg::CMD_READ_MODE);
    step(1);
    cmp("dq_out", 32'h0A3, 32'(dq_out));
    take(2'b01, 8'hA4);
    colchg(8'h09, 8'hA9);
    apb(1'b1, nfs_pkg::REG_CTRL, 32'h0);
    u_nfs_host.cmd(nfs_pkg::CMD_READ_MODE);
    u_nfs_host.addr5(8'h00, 8'h02, 8'h00, 8'h40);
    u_nfs_host.cmd(nfs_pkg::CMD_READ_MP);
    u_nfs_host.cmd(nfs_pkg::CMD_READ_MODE);
    u_nfs_host.addr5(8'h00, 8'h02, 8'h04, 8'h40);
    u_nfs_host.cmd(nfs_pkg::CMD_READ_GO);
    step(1);
    rd(nfs_pkg::REG_STATUS, 32'h1033, 32'h0011, "status");
    wait_rb();
    u_nfs_host.cmd(nfs_pkg::CMD_STATUS_DIE);
    u_nfs_host.row3(8'h02, 8'h04, 8'h40);
    u_nfs_host.cmd(nfs_pkg::CMD_STATUS);
    step(1);
    rd(nfs_pkg::REG_STATUS, 32'h0100, 32'h0100, "selected");
    colchg(8'h01, 8'h03);
    take(2'b10, 8'h00);
    u_nfs_host.cmd(nfs_pkg::CMD_STATUS_DIE);
    u_nfs_host.row3(8'h02, 8'h00, 8'h40);
    colchg(8'h01, 8'h03);
    u_nfs_host.cmd(nfs_pkg::CMD_SET_FEAT);
    u_nfs_host.put(1'b0, 1'b1, nfs_pkg::FEAT_PCLR);
    u_nfs_host.put(1'b0, 1'b0, 8'h01);
    repeat (3) u_nfs_host.put(1'b0, 1'b0, 8'h00);
    rd(nfs_pkg::REG_CTRL, 32'h3, 32'h1, "ctrl");
    u_nfs_host.cmd(nfs_pkg::CMD_PROG);
    u_nfs_host.addr5(8'h00, 8'h00, 8'h00, 8'h00);
    die1_peek(8'h03);
    apb(1'b1, nfs_pkg::REG_CTRL, 32'h0);
    u_nfs_host.cmd(nfs_pkg::CMD_PROG);
    u_nfs_host.addr5(8'h00, 8'h00, 8'h00, 8'h00);
    u_nfs_host.put(1'b0, 1'b0, 8'h5A);
    u_nfs_host.cmd(nfs_pkg::CMD_PROG_CACHE);
    step(10);
    rd(nfs_pkg::REG_STATUS, 32'h1033, 32'h0022, "status");
    step(60);
    rd(nfs_pkg::REG_STATUS, 32'h1033, 32'h0023, "status");
    wait_rb();
    u_nfs_host.cmd(nfs_pkg::CMD_STATUS);
    step(1);
    cmp("dq_out", 32'h0E0, 32'(dq_out));
    die1_peek(8'hFF);
    u_nfs_host.cmd(nfs_pkg::CMD_ERASE);
    u_nfs_host.row3(8'h00, 8'h00, 8'h40);
    u_nfs_host.cmd(nfs_pkg::CMD_ERASE_GO);
    u_nfs_host.cmd(nfs_pkg::CMD_STATUS);
    step(1);
    cmp("dq_out", 32'h080, 32'(dq_out));
    wait_rb();
    step(1);
    cmp("dq_out", 32'h0E0, 32'(dq_out));
    tally_and_finish();
  end
endmodule : tb
